// ===== oss_pkg.sv
// Package: constants, states and carriers for the oscillator switch sequencer
package oss_pkg;
    // ******************************************************************
    // Unlock and relock keys
    // ******************************************************************
    localparam logic [31:0] KEY_FIRST = 32'hAA996655;
    localparam logic [31:0] KEY_SECOND = 32'h556699AA;
    localparam logic [31:0] KEY_RELOCK = 32'h00000000;

    // ******************************************************************
    // Field layout, reset values, timing
    // ******************************************************************
    localparam int SRC_W = 3;
    localparam int NSRC = 8;
    localparam logic [2:0] SRC_RESET = 3'h0;
    // Source 0 is the one running out of reset
    localparam logic [7:0] EN_RESET = 8'h01;
    localparam int NEW_CLK_WAIT = 10;
    localparam logic [3:0] WAIT_LAST = 4'(NEW_CLK_WAIT - 1);
    localparam logic [3:0] WAIT_ZERO = 4'h0;
    localparam logic [3:0] WAIT_ONE = 4'h1;

    typedef logic [2:0] oss_src_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_START = 3'b010,
        ST_READY = 3'b011,
        ST_COUNT = 3'b100,
        ST_DONE = 3'b101
    } oss_state_e;

    typedef enum logic [1:0] {
        KS_LOCKED = 2'b00,
        KS_HALF = 2'b01,
        KS_OPEN = 2'b10
    } oss_key_e;

    // Control register write from software
    typedef struct packed {
        logic wr;
        oss_src_t requested_source_select;
        logic set_switch;
        logic freeze_wr;
        logic freeze_val;
    } oss_ctrl_wr_s;

    // Running status and configuration of each oscillator
    typedef struct packed {
        logic [NSRC-1:0] running;
        logic [NSRC-1:0] needs_xtal;
        logic [NSRC-1:0] uses_pll;
        logic [NSRC-1:0] keep_on;
    } oss_osc_info_s;
endpackage

// ===== oss_top.sv
// Module: oscillator switch sequencer with key lock and freeze
module oss_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Key and control writes
    input wire logic KEY_WR,
    input wire logic [31:0] KEY_DATA,
    input wire oss_pkg::oss_ctrl_wr_s CTRL_WR,
    // Oscillator status, from other clock domains
    input wire oss_pkg::oss_osc_info_s OSC_INFO,
    input wire logic OST_EXPIRED,
    input wire logic PLL_LOCK,
    input wire logic NEW_CLK_TICK,
    input wire logic FAIL_DETECT,
    // Control and status outputs
    output logic [2:0] CURRENT_SOURCE_SELECT,
    output logic [2:0] REQUESTED_SOURCE_SELECT,
    output logic SWITCH_REQUEST_BIT,
    output logic CLOCK_FAILURE_FLAG,
    output logic PLL_SETTLED,
    output logic UNLOCKED,
    output logic CLOCK_SELECT_FREEZE,
    output logic [7:0] OSC_ENABLE,
    output logic SWITCH_BUSY
);
    // ******************************************************************
    // Input synchronisers
    // ******************************************************************
    logic [3:0] s1_q, s2_q;
    logic s3_q;
    logic tick_rise;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= {NEW_CLK_TICK, FAIL_DETECT, PLL_LOCK, OST_EXPIRED};
            s2_q <= s1_q;
            s3_q <= s2_q[3];
        end
    end
    wire ost_ok = s2_q[0];
    wire pll_ok = s2_q[1];
    wire fail_in = s2_q[2];
    // New clock is sampled, so each of its rising edges is one tick here
    assign tick_rise = s2_q[3] & ~s3_q;

    logic [7:0] run_s1_q, run_s2_q;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            run_s1_q <= 8'h00;
            run_s2_q <= 8'h00;
        end else begin
            run_s1_q <= OSC_INFO.running;
            run_s2_q <= run_s1_q;
        end
    end

    // ******************************************************************
    // Key lock
    // ******************************************************************
    oss_pkg::oss_key_e key_q, key_d;
    logic unl_q, unl_d;
    always_comb begin
        key_d = key_q;
        if (KEY_WR) begin
            if (KEY_DATA == oss_pkg::KEY_RELOCK)
                key_d = oss_pkg::KS_LOCKED;
            else if (key_q == oss_pkg::KS_LOCKED && KEY_DATA == oss_pkg::KEY_FIRST)
                key_d = oss_pkg::KS_HALF;
            else if (key_q == oss_pkg::KS_HALF && KEY_DATA == oss_pkg::KEY_SECOND)
                key_d = oss_pkg::KS_OPEN;
            else
                key_d = oss_pkg::KS_LOCKED;
        end
        // Status port comes straight from a flop, so decode the next state
        unl_d = (key_d == oss_pkg::KS_OPEN);
    end
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            key_q <= oss_pkg::KS_LOCKED;
            unl_q <= 1'b0;
        end else begin
            key_q <= key_d;
            unl_q <= unl_d;
        end
    end
    wire wr_ok = CTRL_WR.wr && key_q == oss_pkg::KS_OPEN;

    // ******************************************************************
    // Switch sequencer
    // ******************************************************************
    oss_pkg::oss_state_e st_q, st_d;
    logic [2:0] cur_q, cur_d, req_q, req_d, old_q, old_d;
    logic sw_q, sw_d, cf_q, cf_d, pll_q, pll_d, frz_q, frz_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] en_q, en_d;
    logic busy_q, busy_d;
    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        req_d = req_q;
        old_d = old_q;
        sw_d = sw_q;
        cnt_d = cnt_q;
        en_d = en_q;
        frz_d = frz_q;
        cf_d = cf_q | fail_in;
        pll_d = pll_ok;
        if (wr_ok) begin
            if (!frz_q && st_q == oss_pkg::ST_IDLE)
                req_d = CTRL_WR.requested_source_select;
            if (CTRL_WR.set_switch && !frz_q)
                sw_d = 1'b1;
            if (CTRL_WR.freeze_wr)
                frz_d = CTRL_WR.freeze_val | frz_q;
        end
        case (st_q)
            oss_pkg::ST_IDLE: begin
                if (sw_q) st_d = oss_pkg::ST_CHECK;
            end
            oss_pkg::ST_CHECK: begin
                if (cur_q == req_q) begin
                    sw_d = 1'b0;
                    st_d = oss_pkg::ST_IDLE;
                end else begin
                    cf_d = 1'b0;
                    pll_d = 1'b0;
                    old_d = cur_q;
                    st_d = oss_pkg::ST_START;
                end
            end
            oss_pkg::ST_START: begin
                pll_d = 1'b0;
                if (!run_s2_q[req_q]) en_d[req_q] = 1'b1;
                st_d = oss_pkg::ST_READY;
            end
            oss_pkg::ST_READY: begin
                if ((!OSC_INFO.needs_xtal[req_q] || ost_ok) &&
                    (!OSC_INFO.uses_pll[req_q] || pll_ok)) begin
                    cnt_d = oss_pkg::WAIT_ZERO;
                    st_d = oss_pkg::ST_COUNT;
                end
            end
            oss_pkg::ST_COUNT: begin
                if (tick_rise) begin
                    cnt_d = cnt_q + oss_pkg::WAIT_ONE;
                    if (cnt_q == oss_pkg::WAIT_LAST) st_d = oss_pkg::ST_DONE;
                end
            end
            oss_pkg::ST_DONE: begin
                cur_d = req_q;
                sw_d = 1'b0;
                if (!OSC_INFO.keep_on[old_q] && old_q != req_q)
                    en_d[old_q] = 1'b0;
                st_d = oss_pkg::ST_IDLE;
            end
            default: st_d = oss_pkg::ST_IDLE;
        endcase
        // Failure events win over the clear at switch start
        if (fail_in) cf_d = 1'b1;
        busy_d = (st_d != oss_pkg::ST_IDLE);
    end
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= oss_pkg::ST_IDLE;
            cur_q <= oss_pkg::SRC_RESET;
            req_q <= oss_pkg::SRC_RESET;
            old_q <= oss_pkg::SRC_RESET;
            sw_q <= 1'b0;
            cf_q <= 1'b0;
            pll_q <= 1'b0;
            frz_q <= 1'b0;
            cnt_q <= oss_pkg::WAIT_ZERO;
            en_q <= oss_pkg::EN_RESET;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            req_q <= req_d;
            old_q <= old_d;
            sw_q <= sw_d;
            cf_q <= cf_d;
            pll_q <= pll_d;
            frz_q <= frz_d;
            cnt_q <= cnt_d;
            en_q <= en_d;
            busy_q <= busy_d;
        end
    end

    // Busy is status only; the processor is never stalled
    assign CURRENT_SOURCE_SELECT = cur_q;
    assign REQUESTED_SOURCE_SELECT = req_q;
    assign SWITCH_REQUEST_BIT = sw_q;
    assign CLOCK_FAILURE_FLAG = cf_q;
    assign PLL_SETTLED = pll_q;
    assign UNLOCKED = unl_q;
    assign CLOCK_SELECT_FREEZE = frz_q;
    assign OSC_ENABLE = en_q;
    assign SWITCH_BUSY = busy_q;

    // ******************************************************************
    // Assertions
    // ******************************************************************
    sequence s_done;
        st_q == oss_pkg::ST_DONE;
    endsequence
    a_redundant_abort: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == oss_pkg::ST_CHECK && cur_q == req_q) |=> !sw_q && st_q == oss_pkg::ST_IDLE)
        else $error("redundant request not aborted");
    a_start_clears: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == oss_pkg::ST_CHECK && cur_q != req_q && !fail_in) |=> !cf_q && !pll_q)
        else $error("flags not cleared at switch start");
    a_osc_powered: assert property (@(posedge CLOCK) disable iff (!RST_N)
        st_q == oss_pkg::ST_START |=> en_q[req_q] || run_s2_q[req_q] || $past(run_s2_q[req_q]))
        else $error("requested oscillator not powered");
    a_wait_ost: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == oss_pkg::ST_READY && OSC_INFO.needs_xtal[req_q] && !ost_ok)
        |=> st_q == oss_pkg::ST_READY)
        else $error("left wait before start-up timer");
    a_wait_pll: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == oss_pkg::ST_READY && OSC_INFO.uses_pll[req_q] && !pll_ok)
        |=> st_q == oss_pkg::ST_READY)
        else $error("left wait before PLL lock");
    a_ten_ticks: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == oss_pkg::ST_COUNT && !tick_rise) |=> st_q == oss_pkg::ST_COUNT && $stable(cnt_q))
        else $error("count moved without a new-clock cycle");
    a_count_exact: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(st_q == oss_pkg::ST_DONE) |-> $past(cnt_q) == oss_pkg::WAIT_LAST)
        else $error("changeover before ten new-clock cycles");
    a_done_update: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_done |=> !sw_q && cur_q == $past(req_q))
        else $error("completion did not clear request or copy source");
    a_freeze_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
        frz_q && st_q == oss_pkg::ST_IDLE |=> req_q == $past(req_q))
        else $error("selection changed while frozen");
    a_lock_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (key_q != oss_pkg::KS_OPEN && !sw_q) |=> !sw_q || $past(st_q) != oss_pkg::ST_IDLE
        || $past(sw_q))
        else $error("request accepted while locked");
    a_relock: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (KEY_WR && KEY_DATA == oss_pkg::KEY_RELOCK) |=> key_q == oss_pkg::KS_LOCKED)
        else $error("zero key did not relock");
endmodule

// ===== tb_top.sv
// Self-checking testbench for the oscillator switch sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ******************************************************************
    // Stimulus and observed signals
    // ******************************************************************
    typedef struct packed {
        logic [31:0] k1;
        logic [31:0] k2;
        logic ok;
    } oss_krow_s;

    logic CLOCK = 1'h0;
    logic RST_N = 1'h0;
    logic KEY_WR = 1'h0;
    logic [31:0] KEY_DATA = 32'h0;
    oss_pkg::oss_ctrl_wr_s CTRL_WR = '0;
    oss_pkg::oss_osc_info_s OSC_INFO = {8'h01, 8'h04, 8'h08, 8'h04};
    logic OST_EXPIRED = 1'h0;
    logic PLL_LOCK = 1'h0;
    logic NEW_CLK_TICK = 1'h0;
    logic FAIL_DETECT = 1'h0;
    logic [2:0] CURRENT_SOURCE_SELECT, REQUESTED_SOURCE_SELECT;
    logic SWITCH_REQUEST_BIT, CLOCK_FAILURE_FLAG, PLL_SETTLED, UNLOCKED;
    logic CLOCK_SELECT_FREEZE, SWITCH_BUSY;
    logic [7:0] OSC_ENABLE;
    int bad_count = 0;
    int tests_run = 0;
    oss_krow_s rows[5] = '{
        '{oss_pkg::KEY_FIRST, oss_pkg::KEY_SECOND, 1'h1},
        '{oss_pkg::KEY_SECOND, oss_pkg::KEY_FIRST, 1'h0},
        '{oss_pkg::KEY_FIRST, oss_pkg::KEY_FIRST, 1'h0},
        '{oss_pkg::KEY_FIRST, oss_pkg::KEY_RELOCK, 1'h0},
        '{oss_pkg::KEY_FIRST, 32'h12345678, 1'h0}};

    always #50 CLOCK = ~CLOCK;

    oss_top uut (.CLOCK(CLOCK), .RST_N(RST_N), .KEY_WR(KEY_WR), .KEY_DATA(KEY_DATA),
        .CTRL_WR(CTRL_WR), .OSC_INFO(OSC_INFO), .OST_EXPIRED(OST_EXPIRED),
        .PLL_LOCK(PLL_LOCK), .NEW_CLK_TICK(NEW_CLK_TICK), .FAIL_DETECT(FAIL_DETECT),
        .CURRENT_SOURCE_SELECT(CURRENT_SOURCE_SELECT),
        .REQUESTED_SOURCE_SELECT(REQUESTED_SOURCE_SELECT),
        .SWITCH_REQUEST_BIT(SWITCH_REQUEST_BIT), .CLOCK_FAILURE_FLAG(CLOCK_FAILURE_FLAG),
        .PLL_SETTLED(PLL_SETTLED), .UNLOCKED(UNLOCKED),
        .CLOCK_SELECT_FREEZE(CLOCK_SELECT_FREEZE), .OSC_ENABLE(OSC_ENABLE),
        .SWITCH_BUSY(SWITCH_BUSY));

    // ******************************************************************
    // Shared tasks
    // ******************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_reset;
        chk("reset state", {oss_pkg::EN_RESET, 12'h0}, {OSC_ENABLE, CURRENT_SOURCE_SELECT,
            REQUESTED_SOURCE_SELECT, SWITCH_REQUEST_BIT, UNLOCKED, CLOCK_FAILURE_FLAG,
            PLL_SETTLED, CLOCK_SELECT_FREEZE, SWITCH_BUSY});
    endtask

    task automatic key(input logic [31:0] d);
        @(posedge CLOCK);
        KEY_WR <= 1'h1;
        KEY_DATA <= d;
        @(posedge CLOCK);
        KEY_WR <= 1'h0;
    endtask

    // Freeze writes carry no switch request
    task automatic req(input logic [2:0] src, input logic sw, input logic fw);
        @(posedge CLOCK);
        CTRL_WR <= '{1'h1, src, sw, fw, fw};
        @(posedge CLOCK);
        CTRL_WR <= '0;
    endtask

    // Tick stays high two cycles so the synchroniser cannot miss it
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge CLOCK);
            NEW_CLK_TICK <= 1'h1;
            repeat (2) @(posedge CLOCK);
            NEW_CLK_TICK <= 1'h0;
            @(posedge CLOCK);
        end
    endtask

    task automatic wait_sw0(input int n);
        int i;
        i = 0;
        @(negedge CLOCK);
        while (SWITCH_REQUEST_BIT !== 1'h0 && i < n) begin
            @(negedge CLOCK);
            i++;
        end
        chk("switch_request_bit", 32'h0, SWITCH_REQUEST_BIT);
    endtask

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ******************************************************************
    // Test sequence
    // ******************************************************************
    initial begin
        #(100 * 4000);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge CLOCK);
        RST_N <= 1'h1;
        @(negedge CLOCK);
        chk_reset();
        $display("reset test done");
        foreach (rows[i]) begin
            key(oss_pkg::KEY_RELOCK);
            key(rows[i].k1);
            key(rows[i].k2);
            @(negedge CLOCK);
            chk("unlocked", {31'h0, rows[i].ok}, UNLOCKED);
        end
        $display("key table test done");
        key(oss_pkg::KEY_RELOCK);
        req(3'h5, 1'h1, 1'h0);
        repeat (3) @(negedge CLOCK);
        chk("locked write", 32'h0, {REQUESTED_SOURCE_SELECT, SWITCH_REQUEST_BIT});
        key(oss_pkg::KEY_FIRST);
        key(oss_pkg::KEY_SECOND);
        req(3'h0, 1'h1, 1'h0);
        @(negedge CLOCK);
        chk("request taken", 32'h1, SWITCH_REQUEST_BIT);
        wait_sw0(10);
        chk("redundant source", {3'h0, 8'h01}, {CURRENT_SOURCE_SELECT, OSC_ENABLE});
        $display("redundant test done");
        // Crystal source 2 with a pending failure flag and early ticks
        @(posedge CLOCK);
        FAIL_DETECT <= 1'h1;
        repeat (4) @(posedge CLOCK);
        FAIL_DETECT <= 1'h0;
        repeat (4) @(negedge CLOCK);
        chk("failure flag", 32'h1, CLOCK_FAILURE_FLAG);
        req(3'h2, 1'h1, 1'h0);
        repeat (6) @(negedge CLOCK);
        chk("failure cleared", 32'h0, CLOCK_FAILURE_FLAG);
        chk("new source on", 32'h1, OSC_ENABLE[2]);
        tick(12);
        @(negedge CLOCK);
        chk("held for timer", 32'h1, SWITCH_REQUEST_BIT);
        chk("busy", 32'h1, SWITCH_BUSY);
        @(posedge CLOCK);
        OST_EXPIRED <= 1'h1;
        repeat (6) @(posedge CLOCK);
        tick(9);
        repeat (8) @(negedge CLOCK);
        chk("nine ticks", 32'h1, SWITCH_REQUEST_BIT);
        tick(1);
        wait_sw0(12);
        chk("current source", 32'h2, CURRENT_SOURCE_SELECT);
        chk("idle", 32'h0, SWITCH_BUSY);
        repeat (3) @(negedge CLOCK);
        chk("old source off", 32'h0, OSC_ENABLE[0]);
        $display("crystal switch test done");
        // PLL source 3; source 2 is kept on by configuration
        req(3'h3, 1'h1, 1'h0);
        tick(12);
        @(negedge CLOCK);
        chk("held for lock", 32'h1, SWITCH_REQUEST_BIT);
        @(posedge CLOCK);
        PLL_LOCK <= 1'h1;
        repeat (6) @(negedge CLOCK);
        chk("pll settled", 32'h1, PLL_SETTLED);
        tick(10);
        wait_sw0(12);
        chk("current source", 32'h3, CURRENT_SOURCE_SELECT);
        repeat (3) @(negedge CLOCK);
        chk("kept source on", 32'h1, OSC_ENABLE[2]);
        $display("pll switch test done");
        // The freeze write carries the selection already held
        req(3'h3, 1'h0, 1'h1);
        @(negedge CLOCK);
        chk("freeze", 32'h1, CLOCK_SELECT_FREEZE);
        req(3'h5, 1'h1, 1'h0);
        repeat (4) @(negedge CLOCK);
        chk("frozen selection", {3'h3, 1'h0}, {REQUESTED_SOURCE_SELECT, SWITCH_REQUEST_BIT});
        $display("freeze test done");
        // Reset in mid-run must drop freeze, unlock and selections
        @(posedge CLOCK);
        RST_N <= 1'h0;
        repeat (2) @(posedge CLOCK);
        RST_N <= 1'h1;
        @(negedge CLOCK);
        chk_reset();
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule
